// *** verilog/mcc_ctrl.sv ***
/*
  Message controller: channel_change_reply sequencing and class_ident_request
  exchange, with an APB register file.
  Assumes all message inputs come from framer logic on pclk, so none is synchronised.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - Every accepted channel_change_request gets a channel_change_reply.
// - The first reply goes out on the old upstream before retuning.
// - Request naming current channels gets an already-on-channel reply there.
// - Requests arriving during a channel change are dropped.
// - Second reply after arrival only when no MAC reinit was forced.
// - Reply carries the request's 16-bit transaction id and 8-bit code.
// - With privacy, reply carries key sequence and digest placed last.
// - Optional jump element holds the jump length in timestamp ticks.
// - Jump timing uses the 32-bit SYNC timestamp at 10.24 MHz.
// - Optional start element holds planned start and accuracy in ticks.
// - Class request is sent right after ranging complete.
// - Initialization holds until a class_ident_reply with a success or permanent-reject code arrives, or the retries run out.
// - Class request carries service tag and class with bits 31:1 zero.
// - Temporary reject clears retry counter and resends the request.
// - Permanent reject aborts registration and rescans, excluding this channel.
// - Success code resumes registration.
// - Missing initialization element forces full MAC reinit, no second reply.
module mcc_ctrl (
  // Clock, reset and enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Framer receive side.
  input wire logic ccreq_valid,
  input wire mcc_pkg::mcc_ccreq_t ccreq,
  input wire logic cirsp_valid,
  input wire logic [7:0] cirsp_code,
  input wire logic [31:0] sync_ts,
  input wire logic [13:0] temp_service_tag,
  // Framer transmit side.
  output logic tx_valid,
  input wire logic tx_ready,
  output mcc_pkg::mcc_txmsg_t tx_msg,
  // Tuner and initialization sequencer.
  input wire logic ranging_done,
  input wire logic tune_done,
  output logic retune,
  output logic mac_reinit,
  output logic init_hold,
  output logic reg_resume,
  output logic rescan_excl,
  output logic ci_failed
);
  logic [4:0] ctrl_q, ctrl_d;
  logic [3:0] keyseq_q, keyseq_d;
  logic [31:0] jlen_q, jlen_d, sofs_q, sofs_d, acc_q, acc_d, tmo_q, tmo_d;
  logic [7:0] maxrty_q, maxrty_d;
  logic ign_q, ign_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  mcc_pkg::mcc_cc_st_t cc_q, cc_d;
  mcc_pkg::mcc_ci_st_t ci_q, ci_d;
  logic [15:0] txn_q, txn_d;
  logic reinit_q, reinit_d, stay_q, stay_d, retune_q, retune_d, mreinit_q, mreinit_d;
  logic txv_q, txv_d;
  mcc_pkg::mcc_txmsg_t txm_q, txm_d;
  logic [31:0] tmr_q, tmr_d;
  logic [7:0] rty_q, rty_d;
  logic hold_q, hold_d, resume_q, resume_d, rescan_q, rescan_d, fail_q, fail_d;
  logic apb_wr, apb_setup, cc_acc, ci_acc, cc_take;

  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pready_q && pwrite;
  assign cc_acc = txv_q && tx_ready && (txm_q.kind == mcc_pkg::MSG_CC_REPLY);
  assign ci_acc = txv_q && tx_ready && (txm_q.kind == mcc_pkg::MSG_CI_REQ);
  assign cc_take = ccreq_valid && (cc_q == mcc_pkg::CC_IDLE);

  // APB slave: answers in the first access cycle; unmapped addresses flag an error.
  always_comb begin
    ctrl_d = ctrl_q;
    keyseq_d = keyseq_q;
    jlen_d = jlen_q;
    sofs_d = sofs_q;
    acc_d = acc_q;
    tmo_d = tmo_q;
    maxrty_d = maxrty_q;
    // Set wins over a write-one clear so no dropped request goes unreported.
    ign_d = ign_q || (ccreq_valid && !cc_take);
    pready_d = apb_setup;
    pslverr_d = 1'b0;
    prdata_d = 32'h0000_0000;
    if (apb_setup) begin
      case (paddr)
        mcc_pkg::ADDR_CTRL: prdata_d = {27'h000_0000, ctrl_q};
        mcc_pkg::ADDR_KEYSEQ: prdata_d = {28'h000_0000, keyseq_q};
        mcc_pkg::ADDR_JUMP_LEN: prdata_d = jlen_q;
        mcc_pkg::ADDR_START_OFS: prdata_d = sofs_q;
        mcc_pkg::ADDR_ACCURACY: prdata_d = acc_q;
        mcc_pkg::ADDR_CI_TMO: prdata_d = tmo_q;
        mcc_pkg::ADDR_CI_MAXRTY: prdata_d = {24'h00_0000, maxrty_q};
        mcc_pkg::ADDR_STATUS: prdata_d = {16'h0000, rty_q, 1'b0, ci_q, cc_q, ign_q};
        default: pslverr_d = 1'b1;
      endcase
      if (pwrite) begin
        prdata_d = 32'h0000_0000;
      end
    end
    if (apb_wr && !pslverr_q) begin
      case (paddr)
        mcc_pkg::ADDR_CTRL: ctrl_d = pwdata[4:0];
        mcc_pkg::ADDR_KEYSEQ: keyseq_d = pwdata[3:0];
        mcc_pkg::ADDR_JUMP_LEN: jlen_d = pwdata;
        mcc_pkg::ADDR_START_OFS: sofs_d = pwdata;
        mcc_pkg::ADDR_ACCURACY: acc_d = pwdata;
        mcc_pkg::ADDR_CI_TMO: tmo_d = pwdata;
        mcc_pkg::ADDR_CI_MAXRTY: maxrty_d = pwdata[7:0];
        mcc_pkg::ADDR_STATUS: begin
          if (pwdata[mcc_pkg::STAT_IGN] && !(ccreq_valid && !cc_take)) begin
            ign_d = 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= mcc_pkg::CTRL_RST;
      keyseq_q <= 4'h0;
      jlen_q <= 32'h0000_0000;
      sofs_q <= 32'h0000_0000;
      acc_q <= 32'h0000_0000;
      tmo_q <= mcc_pkg::CI_TMO_RST;
      maxrty_q <= mcc_pkg::CI_MAXRTY_RST;
      ign_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      ctrl_q <= ctrl_d;
      keyseq_q <= keyseq_d;
      jlen_q <= jlen_d;
      sofs_q <= sofs_d;
      acc_q <= acc_d;
      tmo_q <= tmo_d;
      maxrty_q <= maxrty_d;
      ign_q <= ign_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Channel change sequencer and the shared transmit slot.
  always_comb begin
    cc_d = cc_q;
    txn_d = txn_q;
    reinit_d = reinit_q;
    stay_d = stay_q;
    retune_d = 1'b0;
    mreinit_d = 1'b0;
    txv_d = txv_q && !tx_ready;
    txm_d = txm_q;
    case (cc_q)
      mcc_pkg::CC_IDLE: begin
        if (ccreq_valid) begin
          txn_d = ccreq.txn_id;
          stay_d = !ccreq.change_needed;
          // A missing technique element or option 0 means full reinit on arrival.
          reinit_d = !ccreq.init_present ||
                     (ccreq.init_opt == mcc_pkg::INIT_OPT_REINIT);
          cc_d = mcc_pkg::CC_TX_OLD;
        end
      end
      mcc_pkg::CC_TX_OLD: begin
        if (cc_acc) begin
          cc_d = stay_q ? mcc_pkg::CC_IDLE : mcc_pkg::CC_RETUNE;
          retune_d = !stay_q;
        end
      end
      mcc_pkg::CC_RETUNE: begin
        if (tune_done) begin
          cc_d = reinit_q ? mcc_pkg::CC_IDLE : mcc_pkg::CC_TX_NEW;
          mreinit_d = reinit_q;
        end
      end
      mcc_pkg::CC_TX_NEW: begin
        if (cc_acc) begin
          cc_d = mcc_pkg::CC_IDLE;
        end
      end
      default: cc_d = mcc_pkg::CC_IDLE;
    endcase
    // The slot is refilled only once empty, so the framer sees a stable message.
    if (!txv_d) begin
      txm_d = '0;
      if ((cc_d == mcc_pkg::CC_TX_OLD || cc_d == mcc_pkg::CC_TX_NEW) && !cc_acc) begin
        txv_d = 1'b1;
        txm_d.kind = mcc_pkg::MSG_CC_REPLY;
        txm_d.txn_id = txn_d;
        txm_d.conf = (cc_d == mcc_pkg::CC_TX_NEW) ? mcc_pkg::CONF_ARRIVE :
                     (stay_d ? mcc_pkg::CONF_ALREADY : mcc_pkg::CONF_DEPART);
        // Jump figures are raw SYNC ticks; the wrap is left to the headend.
        txm_d.jump_incl = ctrl_q[mcc_pkg::CTRL_JUMP_EN] && !stay_d;
        txm_d.jump_len = jlen_q;
        txm_d.start_incl = ctrl_q[mcc_pkg::CTRL_START_EN] && !stay_d;
        txm_d.start_time = sync_ts + sofs_q;
        txm_d.accuracy = acc_q;
        txm_d.privacy = ctrl_q[mcc_pkg::CTRL_PRIV];
        txm_d.key_seq = keyseq_q;
        txm_d.digest_last = ctrl_q[mcc_pkg::CTRL_PRIV];
      end else if (ci_q == mcc_pkg::CI_SEND && !ci_acc) begin
        txv_d = 1'b1;
        txm_d.kind = mcc_pkg::MSG_CI_REQ;
        txm_d.service_tag = temp_service_tag;
        txm_d.dev_class = {31'h0000_0000, ctrl_q[mcc_pkg::CTRL_CPE]};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cc_q <= mcc_pkg::CC_IDLE;
      txn_q <= 16'h0000;
      reinit_q <= 1'b0;
      stay_q <= 1'b0;
      retune_q <= 1'b0;
      mreinit_q <= 1'b0;
      txv_q <= 1'b0;
      txm_q <= '0;
    end else if (ce) begin
      cc_q <= cc_d;
      txn_q <= txn_d;
      reinit_q <= reinit_d;
      stay_q <= stay_d;
      retune_q <= retune_d;
      mreinit_q <= mreinit_d;
      txv_q <= txv_d;
      txm_q <= txm_d;
    end
  end

  // Class identification sequencer with timeout and retry count.
  always_comb begin
    ci_d = ci_q;
    tmr_d = tmr_q;
    rty_d = rty_q;
    rescan_d = 1'b0;
    fail_d = fail_q;
    if (ranging_done) begin
      tmr_d = 32'h0000_0000;
      rty_d = 8'h00;
      fail_d = 1'b0;
      ci_d = ctrl_q[mcc_pkg::CTRL_CLASS_EN] ? mcc_pkg::CI_SEND : mcc_pkg::CI_GO;
    end else begin
      case (ci_q)
        mcc_pkg::CI_SEND: begin
          tmr_d = 32'h0000_0000;
          if (ci_acc) begin
            ci_d = mcc_pkg::CI_WAIT;
          end
        end
        mcc_pkg::CI_WAIT: begin
          tmr_d = tmr_q + 32'h0000_0001;
          if (cirsp_valid && cirsp_code == mcc_pkg::CONF_OK) begin
            ci_d = mcc_pkg::CI_GO;
          end else if (cirsp_valid && cirsp_code == mcc_pkg::CONF_TEMP_REJ) begin
            rty_d = 8'h00;
            ci_d = mcc_pkg::CI_SEND;
          end else if (cirsp_valid && cirsp_code == mcc_pkg::CONF_PERM_REJ) begin
            ci_d = mcc_pkg::CI_REJECT;
            rescan_d = 1'b1;
          end else if (tmr_q >= tmo_q) begin
            if (rty_q >= maxrty_q) begin
              ci_d = mcc_pkg::CI_FAIL;
              fail_d = 1'b1;
            end else begin
              rty_d = rty_q + 8'h01;
              ci_d = mcc_pkg::CI_SEND;
            end
          end
        end
        mcc_pkg::CI_REJECT: ci_d = mcc_pkg::CI_IDLE;
        mcc_pkg::CI_IDLE, mcc_pkg::CI_GO, mcc_pkg::CI_FAIL: ;
        default: ci_d = mcc_pkg::CI_IDLE;
      endcase
    end
    hold_d = (ci_d == mcc_pkg::CI_SEND) || (ci_d == mcc_pkg::CI_WAIT);
    resume_d = (ci_d == mcc_pkg::CI_GO);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ci_q <= mcc_pkg::CI_IDLE;
      tmr_q <= 32'h0000_0000;
      rty_q <= 8'h00;
      hold_q <= 1'b0;
      resume_q <= 1'b0;
      rescan_q <= 1'b0;
      fail_q <= 1'b0;
    end else if (ce) begin
      ci_q <= ci_d;
      tmr_q <= tmr_d;
      rty_q <= rty_d;
      hold_q <= hold_d;
      resume_q <= resume_d;
      rescan_q <= rescan_d;
      fail_q <= fail_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign tx_valid = txv_q;
  assign tx_msg = txm_q;
  assign retune = retune_q;
  assign mac_reinit = mreinit_q;
  assign init_hold = hold_q;
  assign reg_resume = resume_q;
  assign rescan_excl = rescan_q;
  assign ci_failed = fail_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_reply_before_jump: assert property ($rose(retune_q) |-> $past(cc_acc))
    else $error("retune without old-channel reply");
  a_already_stays: assert property (ce && cc_acc && stay_q |=>
    cc_q == mcc_pkg::CC_IDLE && !retune_q)
    else $error("already-on-channel reply caused a jump");
  a_busy_drop: assert property (ce && ccreq_valid && cc_q != mcc_pkg::CC_IDLE |=> ign_q)
    else $error("dropped request not flagged");
  // A reinit on arrival must leave the slot free of any channel-change reply.
  a_no_arrive_reinit: assert property (ce && cc_q == mcc_pkg::CC_RETUNE &&
    tune_done && reinit_q |=> !(txv_q && txm_q.kind == mcc_pkg::MSG_CC_REPLY))
    else $error("arrival reply after reinit");
  a_reinit_pulse: assert property (ce && cc_q == mcc_pkg::CC_RETUNE &&
    tune_done && reinit_q |=> mreinit_q && cc_q == mcc_pkg::CC_IDLE)
    else $error("reinit not signalled");
  a_txn_echo: assert property (txv_q && txm_q.kind == mcc_pkg::MSG_CC_REPLY |->
    txm_q.txn_id == txn_q)
    else $error("transaction id not echoed");
  a_digest_last: assert property (txv_q && txm_q.kind == mcc_pkg::MSG_CC_REPLY |->
    txm_q.digest_last == txm_q.privacy)
    else $error("privacy attributes inconsistent");
  a_ci_after_range: assert property (ce && ranging_done &&
    ctrl_q[mcc_pkg::CTRL_CLASS_EN] |=>
    ci_q == mcc_pkg::CI_SEND ##1 (txv_q || ci_q == mcc_pkg::CI_SEND))
    else $error("class request not issued after ranging");
  a_ci_class_field: assert property (txv_q && txm_q.kind == mcc_pkg::MSG_CI_REQ |->
    txm_q.dev_class[31:1] == 31'h0000_0000)
    else $error("reserved class bits set");
  a_ci_temp_rej: assert property (ce && !ranging_done && ci_q == mcc_pkg::CI_WAIT &&
    cirsp_valid && cirsp_code == mcc_pkg::CONF_TEMP_REJ |=>
    rty_q == 8'h00 && ci_q == mcc_pkg::CI_SEND && hold_q)
    else $error("temporary reject mishandled");
  a_ci_perm_rej: assert property (ce && !ranging_done && ci_q == mcc_pkg::CI_WAIT &&
    cirsp_valid && cirsp_code == mcc_pkg::CONF_PERM_REJ |=> rescan_q && !resume_q)
    else $error("permanent reject mishandled");
  a_ci_resume: assert property (ce && !ranging_done && ci_q == mcc_pkg::CI_WAIT &&
    cirsp_valid && cirsp_code == mcc_pkg::CONF_OK |=> resume_q && !hold_q)
    else $error("success did not resume registration");
  c_full_jump: cover property (retune_q ##[1:50] cc_acc && txm_q.conf == mcc_pkg::CONF_ARRIVE);
  c_ci_retry: cover property (ci_q == mcc_pkg::CI_WAIT ##1
    ci_q == mcc_pkg::CI_SEND && rty_q != 8'h00);
  c_ci_fail: cover property ($rose(fail_q));
endmodule

// *** verilog/mcc_pkg.sv ***
/*
  Shared constants and carrier types for the subscriber_modem channel-change and
  class-identification message controller.
  Assumes a MAC framer on the same clock that parses and serialises the messages.
*/
package mcc_pkg;
  // APB register byte addresses.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_KEYSEQ = 8'h04;
  localparam logic [7:0] ADDR_JUMP_LEN = 8'h08;
  localparam logic [7:0] ADDR_START_OFS = 8'h0C;
  localparam logic [7:0] ADDR_ACCURACY = 8'h10;
  localparam logic [7:0] ADDR_CI_TMO = 8'h14;
  localparam logic [7:0] ADDR_CI_MAXRTY = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;
  // Control and status register bit positions.
  localparam int CTRL_PRIV = 0;
  localparam int CTRL_CLASS_EN = 1;
  localparam int CTRL_CPE = 2;
  localparam int CTRL_JUMP_EN = 3;
  localparam int CTRL_START_EN = 4;
  localparam int STAT_IGN = 0;
  // Reset values.
  localparam logic [4:0] CTRL_RST = 5'h1A;
  localparam logic [31:0] CI_TMO_RST = 32'h0004_0000;
  localparam logic [7:0] CI_MAXRTY_RST = 8'h03;
  // Confirmation codes and the reinit option value.
  localparam logic [7:0] CONF_OK = 8'h00;
  localparam logic [7:0] CONF_ARRIVE = 8'h01;
  localparam logic [7:0] CONF_TEMP_REJ = 8'h03;
  localparam logic [7:0] CONF_PERM_REJ = 8'h04;
  localparam logic [7:0] CONF_DEPART = 8'h00;
  localparam logic [7:0] CONF_ALREADY = 8'h00;
  localparam logic [7:0] INIT_OPT_REINIT = 8'h00;
  // Message kinds on the transmit port.
  typedef enum logic [1:0] {
    MSG_NONE = 2'b00,
    MSG_CC_REPLY = 2'b01,
    MSG_CI_REQ = 2'b10
  } mcc_kind_t;
  typedef enum logic [2:0] {
    CC_IDLE = 3'b000,
    CC_TX_OLD = 3'b001,
    CC_RETUNE = 3'b010,
    CC_TX_NEW = 3'b011
  } mcc_cc_st_t;
  typedef enum logic [2:0] {
    CI_IDLE = 3'b000,
    CI_SEND = 3'b001,
    CI_WAIT = 3'b010,
    CI_GO = 3'b011,
    CI_REJECT = 3'b100,
    CI_FAIL = 3'b101
  } mcc_ci_st_t;
  // Parsed channel_change_request from the framer.
  typedef struct packed {
    logic [15:0] txn_id;
    logic change_needed;
    logic init_present;
    logic [7:0] init_opt;
  } mcc_ccreq_t;
  // Message handed to the framer for transmission.
  typedef struct packed {
    mcc_kind_t kind;
    logic [15:0] txn_id;
    logic [7:0] conf;
    logic jump_incl;
    logic [31:0] jump_len;
    logic start_incl;
    logic [31:0] start_time;
    logic [31:0] accuracy;
    logic privacy;
    logic [3:0] key_seq;
    logic digest_last;
    logic [13:0] service_tag;
    logic [31:0] dev_class;
  } mcc_txmsg_t;
endpackage

// *** tb/mcc_headend_model.sv ***
/*
  Headend terminal model: accepts messages from the modem controller and answers
  class requests with a code chosen by the bench.
  Assumes the modem transmit port keeps tx_valid and tx_msg steady until accepted.
*/
`timescale 1ns/1ps
module mcc_headend_model (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Transmit handshake from the modem.
  input wire logic tx_valid,
  input wire mcc_pkg::mcc_txmsg_t tx_msg,
  output logic tx_ready,
  // Class reply path.
  output logic cirsp_valid,
  output logic [7:0] cirsp_code,
  // Behaviour chosen by the bench.
  input wire logic [3:0] stall,
  input wire logic ci_answer,
  input wire logic [7:0] ci_code,
  // Local SYNC timestamp of the headend.
  input wire logic [31:0] now_ts,
  // Observed traffic.
  output mcc_pkg::mcc_txmsg_t last_msg,
  output int msg_cnt,
  output int confirm_cnt,
  output logic [15:0] confirm_txn,
  output logic [3:0] confirm_key,
  // Outage window derived from the jump timing.
  output logic jump_wrap,
  output logic [31:0] win_lo,
  output logic [31:0] win_hi
);
  int wait_q;
  int rsp_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
      cirsp_valid <= 1'b0;
      cirsp_code <= 8'h5a;
      wait_q <= 0;
      rsp_q <= 0;
      msg_cnt <= 0;
      confirm_cnt <= 0;
      confirm_txn <= 16'h0000;
      confirm_key <= 4'h0;
      jump_wrap <= 1'b0;
      win_lo <= 32'h0000_0000;
      win_hi <= 32'h0000_0000;
      last_msg <= '0;
    end else begin
      // The code line toggles outside a reply so stale values never look valid.
      cirsp_valid <= 1'b0;
      cirsp_code <= ~cirsp_code;
      tx_ready <= 1'b0;
      if (tx_valid && !tx_ready) begin
        if (wait_q >= int'(stall)) begin
          tx_ready <= 1'b1;
          wait_q <= 0;
        end else begin
          wait_q <= wait_q + 1;
        end
      end
      if (tx_valid && tx_ready) begin
        last_msg <= tx_msg;
        msg_cnt <= msg_cnt + 1;
        if (tx_msg.kind == mcc_pkg::MSG_CC_REPLY && tx_msg.conf == mcc_pkg::CONF_ARRIVE) begin
          confirm_cnt <= confirm_cnt + 1;
          confirm_txn <= tx_msg.txn_id;
          confirm_key <= tx_msg.privacy ? tx_msg.key_seq : 4'h0;
        end
        if (tx_msg.kind == mcc_pkg::MSG_CC_REPLY && tx_msg.start_incl) begin
          // A start already behind the local timestamp is taken as one wrap later.
          jump_wrap <= (tx_msg.start_time < now_ts);
          win_lo <= tx_msg.start_time - tx_msg.accuracy;
          win_hi <= tx_msg.start_time + tx_msg.accuracy + tx_msg.jump_len;
        end
        if (tx_msg.kind == mcc_pkg::MSG_CI_REQ && ci_answer) begin
          rsp_q <= 3;
        end
      end else if (rsp_q > 0) begin
        rsp_q <= rsp_q - 1;
      end
      if (rsp_q == 1) begin
        cirsp_valid <= 1'b1;
        cirsp_code <= ci_code;
      end
    end
  end
endmodule

// *** tb/mcc_ctrl_bench.sv ***
/*
  Self-checking bench for the message controller: APB set-up, channel changes and
  class identification against the headend model.
  Assumes the controller answers APB with no wait states and registers its outputs.
*/
`timescale 1ns/1ps
module mcc_ctrl_bench;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic pready, pslverr, e;
  logic ccreq_valid = 1'b0, cirsp_valid, tx_valid, tx_ready;
  mcc_pkg::mcc_ccreq_t ccreq = '0;
  mcc_pkg::mcc_txmsg_t tx_msg, m;
  logic [7:0] cirsp_code, ci_code = 8'h00;
  logic [31:0] sync_ts = 32'h0000_0000;
  logic [13:0] tag = 14'h0abc;
  logic ranging_done = 1'b0, tune_done = 1'b0, ci_answer = 1'b0;
  logic retune, mac_reinit, init_hold, reg_resume, rescan_excl, ci_failed;
  logic [15:0] confirm_txn;
  logic [3:0] confirm_key;
  logic jump_wrap;
  logic [31:0] win_lo, win_hi;
  int msg_cnt, confirm_cnt, err_count = 0, comparisons = 0;
  int retune_cnt = 0, retune_msgs = 0, reinit_cnt = 0, rescan_cnt = 0, n;

  always #12.5 pclk = ~pclk;
  always @(posedge pclk) sync_ts <= sync_ts + 32'h0000_0001;
  always @(posedge pclk) begin
    if (retune === 1'b1) begin
      retune_cnt++;
      retune_msgs = msg_cnt;
    end
    if (mac_reinit === 1'b1) reinit_cnt++;
    if (rescan_excl === 1'b1) rescan_cnt++;
  end

  mcc_ctrl mcc_ctrl_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ccreq_valid(ccreq_valid), .ccreq(ccreq),
    .cirsp_valid(cirsp_valid), .cirsp_code(cirsp_code), .sync_ts(sync_ts),
    .temp_service_tag(tag), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_msg(tx_msg),
    .ranging_done(ranging_done), .tune_done(tune_done), .retune(retune),
    .mac_reinit(mac_reinit), .init_hold(init_hold), .reg_resume(reg_resume),
    .rescan_excl(rescan_excl), .ci_failed(ci_failed));

  mcc_headend_model mcc_headend_model_inst (.pclk(pclk), .presetn(presetn),
    .tx_valid(tx_valid), .tx_msg(tx_msg), .tx_ready(tx_ready), .cirsp_valid(cirsp_valid),
    .cirsp_code(cirsp_code), .stall(4'h1), .ci_answer(ci_answer), .ci_code(ci_code),
    .now_ts(sync_ts), .last_msg(m), .msg_cnt(msg_cnt), .confirm_cnt(confirm_cnt),
    .confirm_txn(confirm_txn), .confirm_key(confirm_key), .jump_wrap(jump_wrap),
    .win_lo(win_lo), .win_hi(win_hi));

  task end_sim;
    if (err_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Holds the request until pready is seen high at a rising edge, or 50 edges pass.
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) err_count++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wait_msgs(input int cnt);
    int k;
    k = 0;
    while (msg_cnt < cnt && k < 300) begin
      @(posedge pclk);
      k++;
    end
    check("message count", msg_cnt, cnt);
  endtask

  task send_cc(input logic [15:0] id, input logic chg, input logic ip, input logic [7:0] opt);
    @(posedge pclk);
    ccreq_valid <= 1'b1;
    ccreq <= '{id, chg, ip, opt};
    @(posedge pclk);
    ccreq_valid <= 1'b0;
    ccreq <= ~ccreq;
  endtask

  task pulse(input logic tune);
    @(posedge pclk);
    if (tune) tune_done <= 1'b1;
    else ranging_done <= 1'b1;
    @(posedge pclk);
    tune_done <= 1'b0;
    ranging_done <= 1'b0;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    end_sim;
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, mcc_pkg::ADDR_CTRL, 32'h0000_0000);
    check("ctrl reset", q, {27'h0, mcc_pkg::CTRL_RST});
    apb(1'b0, mcc_pkg::ADDR_CI_TMO, 32'h0000_0000);
    check("timeout reset", q, mcc_pkg::CI_TMO_RST);
    apb(1'b0, mcc_pkg::ADDR_CI_MAXRTY, 32'h0000_0000);
    check("retry reset", q, {24'h0, mcc_pkg::CI_MAXRTY_RST});
    apb(1'b0, 8'h20, 32'h0000_0000);
    check("unmapped error", {31'h0, e}, 32'h0000_0001);
    apb(1'b1, mcc_pkg::ADDR_CI_TMO, 32'h0000_0014);
    apb(1'b1, mcc_pkg::ADDR_CTRL, 32'h0000_001f);
    apb(1'b1, mcc_pkg::ADDR_KEYSEQ, 32'h0000_0005);
    apb(1'b1, mcc_pkg::ADDR_JUMP_LEN, 32'h0000_1234);
    apb(1'b1, mcc_pkg::ADDR_ACCURACY, 32'h0000_0010);
    apb(1'b1, mcc_pkg::ADDR_START_OFS, 32'h0000_0100);
    send_cc(16'ha5a5, 1'b1, 1'b1, 8'h01);
    wait_msgs(1);
    check("reply txn", m.txn_id, 16'ha5a5);
    check("reply conf", m.conf, mcc_pkg::CONF_DEPART);
    check("privacy", {m.privacy, m.digest_last, m.key_seq}, 6'h35);
    check("jump length", m.jump_len, 32'h0000_1234);
    check("elements", {m.jump_incl, m.start_incl}, 2'b11);
    check("accuracy", m.accuracy, 32'h0000_0010);
    check("window", win_hi - win_lo, 32'h0000_1254);
    check("no wrap", jump_wrap, 1'b0);
    repeat (3) @(posedge pclk);
    check("reply before jump", retune_msgs, 1);
    send_cc(16'h1111, 1'b1, 1'b1, 8'h01);
    apb(1'b0, mcc_pkg::ADDR_STATUS, 32'h0000_0000);
    check("dropped flag", q[0], 1'b1);
    apb(1'b1, mcc_pkg::ADDR_STATUS, 32'h0000_0001);
    apb(1'b0, mcc_pkg::ADDR_STATUS, 32'h0000_0000);
    check("flag cleared", q[0], 1'b0);
    pulse(1'b1);
    wait_msgs(2);
    check("arrive conf", {m.txn_id, m.conf}, {16'ha5a5, mcc_pkg::CONF_ARRIVE});
    check("confirm count", confirm_cnt, 1);
    check("confirm txn", {confirm_txn, confirm_key}, {16'ha5a5, 4'h5});
    check("retune count", retune_cnt, 1);
    send_cc(16'h2222, 1'b0, 1'b1, 8'h01);
    wait_msgs(3);
    check("already conf", {m.txn_id, m.conf}, {16'h2222, mcc_pkg::CONF_ALREADY});
    check("already privacy", m.privacy, 1'b1);
    repeat (4) @(posedge pclk);
    check("no jump", retune_cnt, 1);
    for (n = 0; n < 2; n++) begin
      send_cc(16'h3333, 1'b1, n[0], mcc_pkg::INIT_OPT_REINIT);
      wait_msgs(4 + n);
      pulse(1'b1);
      repeat (6) @(posedge pclk);
      check("reinit count", reinit_cnt, n + 1);
      check("no second reply", msg_cnt, 4 + n);
    end
    ci_answer <= 1'b1;
    ci_code <= mcc_pkg::CONF_TEMP_REJ;
    pulse(1'b0);
    wait_msgs(6);
    check("class tag", {m.kind, m.service_tag}, {mcc_pkg::MSG_CI_REQ, tag});
    check("class field", m.dev_class, 32'h0000_0001);
    check("hold", init_hold, 1'b1);
    wait_msgs(7);
    ci_code <= mcc_pkg::CONF_OK;
    n = 0;
    while (reg_resume !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    check("resume", {reg_resume, init_hold}, 2'b10);
    ci_code <= mcc_pkg::CONF_PERM_REJ;
    pulse(1'b0);
    wait_msgs(8);
    repeat (8) @(posedge pclk);
    check("rescan", rescan_cnt, 1);
    check("rescan resume", reg_resume, 1'b0);
    ci_answer <= 1'b0;
    pulse(1'b0);
    n = 0;
    while (ci_failed !== 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    check("retries", msg_cnt, 12);
    check("failed", ci_failed, 1'b1);
    end_sim;
  end
endmodule
